// [rtl/sc_flags_pkg.sv]
/*
  Constants for the smart card status flag block: register offsets,
  field positions, reset values and etu delay figures.
  Assumes a 32-bit APB register bus.
*/
package sc_flags_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_ETU = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  // ----------------------------------------
  // Status fields
  // ----------------------------------------
  localparam int B_MP_TX = 0;
  localparam int B_MP_RX = 1;
  localparam int B_TX_DONE = 2;
  localparam int B_PARITY = 3;
  localparam int B_CARD_ERR = 4;
  localparam int B_TX_EMPTY = 7;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int B_TE = 0;
  localparam int B_RE = 1;
  localparam int B_GM = 2;
  localparam int B_BLK = 3;
  localparam int B_SYNC = 4;
  localparam int CTRL_W = 5;
  // ----------------------------------------
  // Interrupt fields
  // ----------------------------------------
  localparam int I_PARITY = 0;
  localparam int I_CARD_ERR = 1;
  localparam int I_TX_DONE = 2;
  localparam int INT_W = 3;
  // ----------------------------------------
  // Reset values and etu delays in half etu
  // ----------------------------------------
  localparam logic RST_TX_DONE = 1'b1;
  localparam logic [15:0] RST_HALF_ETU = 16'h0010;
  localparam logic [2:0] HALVES_GM0_BLK0 = 3'h5;
  localparam logic [2:0] HALVES_GM0_BLK1 = 3'h3;
  localparam logic [2:0] HALVES_GM1 = 3'h2;
endpackage : sc_flags_pkg

// [rtl/smart_card_serial_status_flags.sv]
/*
  Status flag block of a serial channel in smart card mode, with an
  APB register slave and a masked interrupt.
  Assumes the channel supplies same-clock strobes for reception end,
  transmission start, error sampling and controller writes.
*/
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module smart_card_serial_status_flags
  import sc_flags_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel side
  input wire logic rx_char_done,
  input wire logic rx_parity_bad,
  input wire logic tx_start,
  input wire logic tx_empty_flag,
  input wire logic tx_dma_write,
  input wire logic err_sample,
  input wire logic card_err_n,
  output logic rx_buffer_load,
  output logic rx_full_set,
  output logic rx_start_block,
  output logic tx_hold,
  output logic tx_empty_clear,
  output logic transmit_enable,
  output logic rx_enable,
  output logic clock_output_mode,
  output logic block_transfer_mode,
  output logic irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic parity_error_flag, next_parity_error_flag;
  logic card_error_flag, next_card_error_flag;
  logic tx_done_flag, next_tx_done_flag;
  logic multiproc_tx_bit, next_multiproc_tx_bit;
  logic arm_par, next_arm_par;
  logic arm_err, next_arm_err;
  logic arm_txe, next_arm_txe;
  logic [CTRL_W-1:0] ctrl, next_ctrl;
  logic [15:0] half_etu, next_half_etu;
  logic [15:0] half_cnt, next_half_cnt;
  logic [2:0] halves, next_halves;
  logic [INT_W-1:0] int_stat, next_int_stat;
  logic [INT_W-1:0] int_mask, next_int_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_rx_buffer_load, next_rx_full_set;
  logic next_tx_hold, next_tx_empty_clear, next_irq;
  logic err_s1, err_s2;
  logic acc, wr, rd, wr_stat, rd_stat, par_ev, err_ev, etu_end;
  logic [15:0] div;
  logic [2:0] target;
  logic [INT_W-1:0] ev;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, OFS_STATUS) | hit(a, OFS_CTRL) | hit(a, OFS_ETU) |
             hit(a, OFS_INT_STAT) | hit(a, OFS_INT_MASK);
  endfunction : mapped

  // ----------------------------------------
  // Error pin synchroniser
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      err_s1 <= 1'b1;
      err_s2 <= 1'b1;
    end else begin
      err_s1 <= card_err_n;
      err_s2 <= err_s1;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    acc = psel & penable & pready;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    wr_stat = wr & hit(paddr, OFS_STATUS);
    rd_stat = rd & hit(paddr, OFS_STATUS);
    next_pready = psel & penable & ~pready;
    next_pslverr = next_pready & ~mapped(paddr);
    next_prdata = 32'h0000_0000;
    if (next_pready) begin
      case (1'b1)
        hit(paddr, OFS_STATUS): begin
          next_prdata[B_MP_TX] = multiproc_tx_bit;
          next_prdata[B_MP_RX] = 1'b0;
          next_prdata[B_TX_DONE] = tx_done_flag;
          next_prdata[B_PARITY] = parity_error_flag;
          next_prdata[B_CARD_ERR] = card_error_flag;
          next_prdata[B_TX_EMPTY] = tx_empty_flag;
        end
        hit(paddr, OFS_CTRL): next_prdata[CTRL_W-1:0] = ctrl;
        hit(paddr, OFS_ETU): next_prdata[15:0] = half_etu;
        hit(paddr, OFS_INT_STAT): next_prdata[INT_W-1:0] = int_stat;
        hit(paddr, OFS_INT_MASK): next_prdata[INT_W-1:0] = int_mask;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    // A read arms the clear only if it returned 1; any status write disarms.
    next_arm_par = arm_par;
    next_arm_err = arm_err;
    next_arm_txe = arm_txe;
    if (rd_stat) begin
      next_arm_par = prdata[B_PARITY];
      next_arm_err = prdata[B_CARD_ERR];
      next_arm_txe = prdata[B_TX_EMPTY];
    end else if (wr_stat) begin
      next_arm_par = 1'b0;
      next_arm_err = 1'b0;
      next_arm_txe = 1'b0;
    end
    // Parity flag: set wins over a software clear.
    par_ev = rx_char_done & rx_parity_bad & ~parity_error_flag;
    next_parity_error_flag = parity_error_flag;
    if (wr_stat & arm_par & ~pwdata[B_PARITY]) begin
      next_parity_error_flag = 1'b0;
    end
    if (rx_char_done & rx_parity_bad) begin
      next_parity_error_flag = 1'b1;
    end
    // Reception is refused once the flag is up, so strobes are dropped.
    next_rx_buffer_load = rx_char_done & ~parity_error_flag;
    next_rx_full_set = rx_char_done & ~rx_parity_bad & ~parity_error_flag;
    next_tx_hold = next_parity_error_flag & ctrl[B_SYNC];
    // Card error flag.
    err_ev = err_sample & ~err_s2 & ~card_error_flag;
    next_card_error_flag = card_error_flag;
    if (wr_stat & arm_err & ~pwdata[B_CARD_ERR]) begin
      next_card_error_flag = 1'b0;
    end
    if (err_sample & ~err_s2) begin
      next_card_error_flag = 1'b1;
    end
    next_multiproc_tx_bit = multiproc_tx_bit;
    if (wr_stat) begin
      next_multiproc_tx_bit = pwdata[B_MP_TX];
    end
    next_tx_empty_clear = wr_stat & arm_txe & ~pwdata[B_TX_EMPTY];
    // Half-etu timer from transmission start.
    div = (half_etu == 16'h0000) ? 16'h0001 : half_etu;
    if (~ctrl[B_GM] & ~ctrl[B_BLK]) begin
      target = HALVES_GM0_BLK0;
    end else if (~ctrl[B_GM]) begin
      target = HALVES_GM0_BLK1;
    end else begin
      target = HALVES_GM1;
    end
    etu_end = 1'b0;
    next_half_cnt = half_cnt;
    next_halves = halves;
    if (tx_start) begin
      next_half_cnt = div;
      next_halves = target;
    end else if (halves != 3'h0) begin
      if (half_cnt == 16'h0001) begin
        next_half_cnt = div;
        next_halves = halves - 3'h1;
        etu_end = (halves == 3'h1);
      end else begin
        next_half_cnt = half_cnt - 16'h0001;
      end
    end
    // Tx done flag: setting beats clearing.
    next_tx_done_flag = tx_done_flag;
    if (next_tx_empty_clear | tx_dma_write) begin
      next_tx_done_flag = 1'b0;
    end
    if (~ctrl[B_TE] & ~card_error_flag) begin
      next_tx_done_flag = 1'b1;
    end
    if (etu_end & ~card_error_flag & tx_empty_flag) begin
      next_tx_done_flag = 1'b1;
    end
    // Control registers; rx enable has no path to the parity flag.
    next_ctrl = ctrl;
    next_half_etu = half_etu;
    next_int_mask = int_mask;
    if (wr & hit(paddr, OFS_CTRL)) begin
      next_ctrl = pwdata[CTRL_W-1:0];
    end
    if (wr & hit(paddr, OFS_ETU)) begin
      next_half_etu = pwdata[15:0];
    end
    if (wr & hit(paddr, OFS_INT_MASK)) begin
      next_int_mask = pwdata[INT_W-1:0];
    end
    ev = '0;
    ev[I_PARITY] = par_ev;
    ev[I_CARD_ERR] = err_ev;
    ev[I_TX_DONE] = next_tx_done_flag & ~tx_done_flag;
    next_int_stat = int_stat;
    if (wr & hit(paddr, OFS_INT_STAT)) begin
      next_int_stat = int_stat & ~pwdata[INT_W-1:0];
    end
    next_int_stat = next_int_stat | ev;
    next_irq = |(next_int_stat & next_int_mask);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      parity_error_flag <= 1'b0;
      card_error_flag <= 1'b0;
      tx_done_flag <= RST_TX_DONE;
      multiproc_tx_bit <= 1'b0;
      arm_par <= 1'b0;
      arm_err <= 1'b0;
      arm_txe <= 1'b0;
      ctrl <= '0;
      half_etu <= RST_HALF_ETU;
      half_cnt <= 16'h0000;
      halves <= 3'h0;
      int_stat <= '0;
      int_mask <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rx_buffer_load <= 1'b0;
      rx_full_set <= 1'b0;
      tx_hold <= 1'b0;
      tx_empty_clear <= 1'b0;
      irq <= 1'b0;
    end else begin
      parity_error_flag <= next_parity_error_flag;
      card_error_flag <= next_card_error_flag;
      tx_done_flag <= next_tx_done_flag;
      multiproc_tx_bit <= next_multiproc_tx_bit;
      arm_par <= next_arm_par;
      arm_err <= next_arm_err;
      arm_txe <= next_arm_txe;
      ctrl <= next_ctrl;
      half_etu <= next_half_etu;
      half_cnt <= next_half_cnt;
      halves <= next_halves;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      rx_buffer_load <= next_rx_buffer_load;
      rx_full_set <= next_rx_full_set;
      tx_hold <= next_tx_hold;
      tx_empty_clear <= next_tx_empty_clear;
      irq <= next_irq;
    end
  end

  // ----------------------------------------
  // Output aliases of registered state
  // ----------------------------------------
  assign rx_start_block = parity_error_flag;
  assign transmit_enable = ctrl[B_TE];
  assign rx_enable = ctrl[B_RE];
  assign clock_output_mode = ctrl[B_GM];
  assign block_transfer_mode = ctrl[B_BLK];
endmodule : smart_card_serial_status_flags
`default_nettype wire

// [bench/sc_flags_assertions.sv]
/* Assertions on the ports of the status flag block.
   Assumes it is bound to the top module. */
`timescale 1ns/1ps
`default_nettype none
module sc_flags_assertions
  import sc_flags_pkg::*;
(
  // Clock, reset and APB
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Channel side
  input wire logic rx_char_done,
  input wire logic rx_parity_bad,
  input wire logic rx_buffer_load,
  input wire logic rx_full_set,
  input wire logic rx_start_block,
  input wire logic tx_hold,
  input wire logic tx_empty_clear
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic st = paddr[7:2] == OFS_STATUS[7:2];
  wire logic wr = psel && penable && pready && pwrite && st;
  wire logic clr = wr && !pwdata[B_TX_EMPTY];
  wire logic bad = rx_char_done && rx_parity_bad;
  wire logic good = rx_char_done && !rx_parity_bad && !rx_start_block;
  property p_set; bad |=> rx_start_block; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_nofull; bad |=> !rx_full_set; endproperty
  a_nofull: assert property (p_nofull) else $error("full on bad");
  property p_load; good |=> rx_full_set && rx_buffer_load; endproperty
  a_load: assert property (p_load) else $error("no load");
  property p_block; rx_char_done && rx_start_block |=> !rx_buffer_load; endproperty
  a_block: assert property (p_block) else $error("rx not blocked");
  property p_hold; tx_hold |-> rx_start_block; endproperty
  a_hold: assert property (p_hold) else $error("hold without flag");
  property p_keep; rx_start_block && !wr |=> rx_start_block; endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_one; wr && pwdata[B_PARITY] && !bad |=> $stable(rx_start_block); endproperty
  a_one: assert property (p_one) else $error("one write acted");
  property p_mp; pready && !pwrite && st |-> !prdata[B_MP_RX]; endproperty
  a_mp: assert property (p_mp) else $error("rx mp bit set");
  property p_clr; $rose(tx_empty_clear) |-> $past(clr); endproperty
  a_clr: assert property (p_clr) else $error("stray empty clear");
  c_bad: cover property (bad);
  c_clr: cover property (tx_empty_clear);
  c_hold: cover property (tx_hold);
endmodule : sc_flags_assertions
bind smart_card_serial_status_flags sc_flags_assertions sc_flags_assertions_inst (
  .sys_clk(sys_clk),
  .rstn(rstn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .rx_char_done(rx_char_done),
  .rx_parity_bad(rx_parity_bad),
  .rx_buffer_load(rx_buffer_load),
  .rx_full_set(rx_full_set),
  .rx_start_block(rx_start_block),
  .tx_hold(tx_hold),
  .tx_empty_clear(tx_empty_clear)
);
`default_nettype wire

// [bench/card_side.sv]
/* Model of the channel and card beside the flag block.
   Assumes the bench asks for one strobe at a time. */
`timescale 1ns/1ps
`default_nettype none
module card_side (
  // Clock
  input wire logic sys_clk,
  // Channel strobes and levels
  output logic rx_char_done,
  output logic rx_parity_bad,
  output logic tx_start,
  output logic tx_dma_write,
  output logic err_sample,
  output logic tx_empty_flag,
  output logic card_err_n
);
  initial begin
    {rx_char_done, tx_start, tx_dma_write, err_sample} = 4'h0;
    {tx_empty_flag, card_err_n, rx_parity_bad} = 3'b010;
  end
  // The parity level flips after a strobe, so no stale qualifier helps.
  task automatic pulse(input logic [3:0] k);
    @(posedge sys_clk);
    {rx_char_done, tx_start, tx_dma_write, err_sample} <= k;
    @(posedge sys_clk);
    {rx_char_done, tx_start, tx_dma_write, err_sample} <= 4'h0;
    rx_parity_bad <= ~rx_parity_bad;
  endtask : pulse
  task automatic lines(input logic txe, input logic errn, input logic bad);
    @(posedge sys_clk);
    {tx_empty_flag, card_err_n, rx_parity_bad} <= {txe, errn, bad};
  endtask : lines
endmodule : card_side
`default_nettype wire

// [bench/tb_smart_card_serial_status_flags.sv]
/* Bench for the smart card status flags.
   Assumes card_side drives the channel inputs. */
`timescale 1ns/1ps
`default_nettype none
module tb_smart_card_serial_status_flags;
  import sc_flags_pkg::*;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_char_done, rx_parity_bad, tx_start, tx_empty_flag;
  logic tx_dma_write, err_sample, card_err_n, rx_buffer_load;
  logic rx_full_set, rx_start_block, tx_hold, tx_empty_clear;
  logic transmit_enable, rx_enable, clock_output_mode;
  logic block_transfer_mode, irq;
  int n_mismatch = 0, checks = 0, par = 0, txd = 1, cer = 0;
  int mpt = 0, h, n, lat;
  int halves[4] = '{5, 3, 2, 2};
  logic [31:0] ctl[4] = '{32'h1, 32'h9, 32'h5, 32'hD};
  smart_card_serial_status_flags smart_card_serial_status_flags_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rx_char_done(rx_char_done),
    .rx_parity_bad(rx_parity_bad),
    .tx_start(tx_start),
    .tx_empty_flag(tx_empty_flag),
    .tx_dma_write(tx_dma_write),
    .err_sample(err_sample),
    .card_err_n(card_err_n),
    .rx_buffer_load(rx_buffer_load),
    .rx_full_set(rx_full_set),
    .rx_start_block(rx_start_block),
    .tx_hold(tx_hold),
    .tx_empty_clear(tx_empty_clear),
    .transmit_enable(transmit_enable),
    .rx_enable(rx_enable),
    .clock_output_mode(clock_output_mode),
    .block_transfer_mode(block_transfer_mode),
    .irq(irq)
  );
  card_side card_side_inst (
    .sys_clk(sys_clk),
    .rx_char_done(rx_char_done),
    .rx_parity_bad(rx_parity_bad),
    .tx_start(tx_start),
    .tx_dma_write(tx_dma_write),
    .err_sample(err_sample),
    .tx_empty_flag(tx_empty_flag),
    .card_err_n(card_err_n)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : cmp
  // Error answers fold into bit 0 of the read word.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t no ready answer", $time);
    end
    rd = prdata | pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rs();
    apb(1'b0, OFS_STATUS, 32'h0);
    cmp(rd & 32'h9F, {tx_empty_flag, 2'b0, cer[0], par[0], txd[0], 1'b0, mpt[0]});
  endtask : rs
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = OFS_STATUS;
    pwdata = $urandom(86978);
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rs();
    apb(1'b1, OFS_STATUS, 32'hFF);
    mpt = 1;
    rs();
    apb(1'b1, OFS_STATUS, 32'h0);
    mpt = 0;
    rs();
    apb(1'b0, 8'h40, 32'h0);
    cmp(rd, 32'h1);
    $display("test reset done");
    apb(1'b1, OFS_INT_MASK, 32'h1);
    card_side_inst.lines(1'b0, 1'b1, 1'b1);
    card_side_inst.pulse(4'h8);
    @(posedge sys_clk);
    cmp({rx_buffer_load, rx_full_set, rx_start_block}, 3'b101);
    par = 1;
    apb(1'b1, OFS_CTRL, 32'h12);
    repeat (2) @(posedge sys_clk);
    cmp({tx_hold, irq, rx_enable}, 3'b111);
    card_side_inst.pulse(4'h8);
    @(posedge sys_clk);
    cmp({rx_buffer_load, rx_full_set}, 2'b00);
    apb(1'b1, OFS_CTRL, 32'h10);
    rs();
    cmp(rx_enable, 1'b0);
    apb(1'b1, OFS_STATUS, 32'h8);
    apb(1'b1, OFS_STATUS, 32'h0);
    rs();
    apb(1'b1, OFS_INT_MASK, 32'h0);
    repeat (2) @(posedge sys_clk);
    cmp(irq, 1'b0);
    apb(1'b1, OFS_STATUS, 32'h0);
    par = 0;
    rs();
    card_side_inst.lines(1'b0, 1'b1, 1'b0);
    card_side_inst.pulse(4'h8);
    @(posedge sys_clk);
    cmp({rx_buffer_load, rx_full_set}, 2'b11);
    apb(1'b1, OFS_INT_STAT, 32'h7);
    apb(1'b1, OFS_INT_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    cmp(irq, 1'b0);
    $display("test parity done");
    card_side_inst.lines(1'b1, 1'b1, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h1);
    rs();
    apb(1'b1, OFS_STATUS, 32'h0);
    @(posedge sys_clk);
    cmp(tx_empty_clear, 1'b1);
    txd = 0;
    rs();
    card_side_inst.lines(1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge sys_clk);
    card_side_inst.pulse(4'h1);
    card_side_inst.lines(1'b1, 1'b1, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0);
    cer = 1;
    rs();
    apb(1'b1, OFS_STATUS, 32'h0);
    cer = 0;
    txd = 1;
    rs();
    $display("test card error done");
    for (int m = 0; m < 4; m++) begin
      h = 4 + $urandom % 5;
      n = halves[m] * h;
      apb(1'b1, OFS_ETU, h);
      apb(1'b1, OFS_CTRL, ctl[m]);
      rs();
      cmp({block_transfer_mode, clock_output_mode, rx_enable, transmit_enable}, ctl[m][3:0]);
      apb(1'b1, OFS_STATUS, 32'h0);
      apb(1'b1, OFS_INT_STAT, 32'h7);
      apb(1'b1, OFS_INT_MASK, 32'h4);
      card_side_inst.pulse(4'h4);
      lat = 0;
      while (irq !== 1'b1 && lat < 300) begin
        @(posedge sys_clk);
        lat++;
      end
      cmp(lat, n + 1);
      txd = 1;
      rs();
      card_side_inst.pulse(4'h2);
      txd = 0;
      rs();
    end
    $display("test tx timing done");
    end_sim();
  end
endmodule : tb_smart_card_serial_status_flags
`default_nettype wire
